// ### esq_consts.svh
`ifndef ESQ_CONSTS_SVH
`define ESQ_CONSTS_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define ESQ_AXES 4
`define ESQ_TW 24
`define ESQ_AW 8
`define ESQ_NEV 3

// ----------------------------------------------------------------------
// register byte offsets and address block selects (bits 7:5)
// ----------------------------------------------------------------------
`define ESQ_OFF_CTRL 8'h00
`define ESQ_OFF_STAT 8'h04
`define ESQ_OFF_MODE 8'h08
`define ESQ_OFF_ALARM 8'h0C
`define ESQ_OFF_IRQ_STAT 8'h10
`define ESQ_OFF_IRQ_MASK 8'h14
`define ESQ_BLK_RAMP 3'h1
`define ESQ_BLK_DLY 3'h2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ESQ_CTRL_CONTOUR 0
`define ESQ_CTRL_STOP 1
`define ESQ_CTRL_ACK 2
`define ESQ_STAT_ACTIVE 1
`define ESQ_STAT_READY 3
`define ESQ_STAT_POSCTL 4
`define ESQ_STAT_ALARM 5
`define ESQ_STAT_BRAKING 6
`define ESQ_STAT_DRVOFF 7
`define ESQ_MODE_RESET 7
`define ESQ_EV_ENTER 0
`define ESQ_EV_LEAVE 1
`define ESQ_EV_DRVOFF 2

// ----------------------------------------------------------------------
// values and timing
// ----------------------------------------------------------------------
`define ESQ_ALARM_NUM 16'h0BB8
`define ESQ_RESP_OKAY 2'h0
`define ESQ_RESP_SLVERR 2'h2
`define ESQ_CLK_MHZ 25
`define ESQ_RAMP_US 50000
`define ESQ_DLY_US 100000
`define ESQ_RAMP_CYC (`ESQ_RAMP_US * `ESQ_CLK_MHZ)
`define ESQ_DLY_CYC (`ESQ_DLY_US * `ESQ_CLK_MHZ)

`endif

// ### esq_pkg.sv
`include "esq_consts.svh"

package esq_pkg;

  typedef enum logic [1:0] {ESQ_IDLE, ESQ_ACTIVE, ESQ_ACKED} esq_state_t;

  typedef enum logic [3:0] {
    ESQ_SEL_CTRL, ESQ_SEL_STAT, ESQ_SEL_MODE, ESQ_SEL_ALARM, ESQ_SEL_IRQS,
    ESQ_SEL_IRQM, ESQ_SEL_RAMP, ESQ_SEL_DLY, ESQ_SEL_NONE
  } esq_sel_t;

  typedef struct packed {
    logic awvalid;
    logic [`ESQ_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`ESQ_AW-1:0] araddr;
    logic rready;
  } esq_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } esq_axil_rsp_t;

  typedef struct packed {
    logic [`ESQ_TW-1:0] ramp_cnt;
    logic [`ESQ_TW-1:0] dly_cnt;
    logic braking;
    logic drv_en;
  } esq_axis_st_t;

  typedef struct packed {
    logic [`ESQ_NEV-1:0] stat;
    logic [`ESQ_NEV-1:0] mask;
    logic irq;
  } esq_irq_st_t;

  typedef struct packed {
    esq_axil_rsp_t rsp;
    logic aw_hold;
    logic [`ESQ_AW-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [`ESQ_AXES-1:0][`ESQ_TW-1:0] ramp;
    logic [`ESQ_AXES-1:0][`ESQ_TW-1:0] dly;
    esq_state_t fsm;
    logic active;
    logic ready;
    logic posctl;
    logic alarm;
    logic prog_hold;
    logic prog_abort;
    logic pos_correct;
    logic all_off;
  } esq_top_st_t;

endpackage : esq_pkg

// ### esq_axis_brake.sv
`timescale 1ns/1ps
`default_nettype none
`include "esq_consts.svh"

module esq_axis_brake #(
  parameter int TW = `ESQ_TW
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stop,
  input wire logic [TW-1:0] ramp_cycles,
  input wire logic [TW-1:0] delay_cycles,
  output logic braking,
  output logic drive_en
);
  import esq_pkg::*;

  esq_axis_st_t s_q;
  esq_axis_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (!stop)
    begin
      // counters preload so a new stop always sees the latest setting
      s_d.ramp_cnt = ramp_cycles;
      s_d.dly_cnt = delay_cycles;
      s_d.braking = 1'b0;
      s_d.drv_en = 1'b1;
    end
    else
    begin
      if (s_q.ramp_cnt != '0)
        s_d.ramp_cnt = s_q.ramp_cnt - 1'b1;
      if (s_q.dly_cnt != '0)
        s_d.dly_cnt = s_q.dly_cnt - 1'b1;
      s_d.braking = (s_q.ramp_cnt != '0);
      s_d.drv_en = (s_q.dly_cnt != '0);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{ramp_cnt: '0, dly_cnt: '0, braking: 1'b0, drv_en: 1'b1};
    else
      s_q <= s_d;
  end

  assign braking = s_q.braking;
  assign drive_en = s_q.drv_en;

endmodule : esq_axis_brake

`default_nettype wire

// ### esq_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "esq_consts.svh"

module esq_irq (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`ESQ_NEV-1:0] set_ev,
  input wire logic [`ESQ_NEV-1:0] clr_w1c,
  input wire logic mask_we,
  input wire logic [`ESQ_NEV-1:0] mask_wd,
  output logic [`ESQ_NEV-1:0] stat,
  output logic [`ESQ_NEV-1:0] mask,
  output logic irq
);
  import esq_pkg::*;

  esq_irq_st_t s_q;
  esq_irq_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    // set after clear: an event in the clearing cycle is kept
    s_d.stat = (s_q.stat & ~clr_w1c) | set_ev;
    if (mask_we)
      s_d.mask = mask_wd;
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign stat = s_q.stat;
  assign mask = s_q.mask;
  assign irq = s_q.irq;

endmodule : esq_irq

`default_nettype wire

// ### esq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "esq_consts.svh"

module esq_sequencer #(
  parameter logic [`ESQ_TW-1:0] RAMP_CYCLES = `ESQ_TW'(`ESQ_RAMP_CYC),
  parameter logic [`ESQ_TW-1:0] DLY_CYCLES = `ESQ_TW'(`ESQ_DLY_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire esq_pkg::esq_axil_req_t axil_req,
  output esq_pkg::esq_axil_rsp_t axil_rsp,
  output logic irq,
  output logic estop_active,
  output logic control_ready,
  output logic pos_ctrl_active,
  output logic alarm_active,
  output logic prog_hold,
  output logic prog_abort,
  output logic pos_correct,
  output logic [`ESQ_AXES-1:0] axis_braking,
  output logic [`ESQ_AXES-1:0] drive_enable
);
  import esq_pkg::*;

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic esq_sel_t esq_decode(input logic [`ESQ_AW-1:0] a);
    esq_sel_t sel;
    sel = ESQ_SEL_NONE;
    if (a[1:0] != 2'h0)
      sel = ESQ_SEL_NONE;
    else if (a == `ESQ_OFF_CTRL)
      sel = ESQ_SEL_CTRL;
    else if (a == `ESQ_OFF_STAT)
      sel = ESQ_SEL_STAT;
    else if (a == `ESQ_OFF_MODE)
      sel = ESQ_SEL_MODE;
    else if (a == `ESQ_OFF_ALARM)
      sel = ESQ_SEL_ALARM;
    else if (a == `ESQ_OFF_IRQ_STAT)
      sel = ESQ_SEL_IRQS;
    else if (a == `ESQ_OFF_IRQ_MASK)
      sel = ESQ_SEL_IRQM;
    else if (a[7:5] == `ESQ_BLK_RAMP && 32'(a[4:2]) < `ESQ_AXES)
      sel = ESQ_SEL_RAMP;
    else if (a[7:5] == `ESQ_BLK_DLY && 32'(a[4:2]) < `ESQ_AXES)
      sel = ESQ_SEL_DLY;
    return sel;
  endfunction : esq_decode

  function automatic logic [31:0] esq_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : esq_merge

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  esq_top_st_t s_q;
  esq_top_st_t s_d;

  logic [`ESQ_AXES-1:0] brk_w;
  logic [`ESQ_AXES-1:0] den_w;
  logic [`ESQ_NEV-1:0] ev_set;
  logic [`ESQ_NEV-1:0] ev_clr;
  logic mask_we;
  logic [`ESQ_NEV-1:0] irq_stat;
  logic [`ESQ_NEV-1:0] irq_mask;
  logic irq_w;

  // ----------------------------------------------------------------------
  // per-axis braking and drive enable
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `ESQ_AXES; g++)
    begin : g_axis
      esq_axis_brake #(
        .TW(`ESQ_TW)
      ) u_axis (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .stop(s_q.active),
        .ramp_cycles(s_q.ramp[g]),
        .delay_cycles(s_q.dly[g]),
        .braking(brk_w[g]),
        .drive_en(den_w[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------------
  esq_irq u_irq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_ev(ev_set),
    .clr_w1c(ev_clr),
    .mask_we(mask_we),
    .mask_wd(s_q.w_data[`ESQ_NEV-1:0]),
    .stat(irq_stat),
    .mask(irq_mask),
    .irq(irq_w)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic do_write;
  esq_sel_t wsel;
  esq_sel_t rsel;
  logic [2:0] widx;
  logic [2:0] ridx;
  logic [31:0] merged;
  logic stop_req;
  logic ack_req;
  logic rst_req;

  always_comb
  begin
    s_d = s_q;
    ev_set = '0;
    ev_clr = '0;
    mask_we = 1'b0;
    s_d.prog_abort = 1'b0;
    s_d.pos_correct = 1'b0;

    // write channel: address and data are captured in either order
    if (axil_req.awvalid && s_q.rsp.awready)
    begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && s_q.rsp.wready)
    begin
      s_d.w_hold = 1'b1;
      s_d.w_data = axil_req.wdata;
      s_d.w_strb = axil_req.wstrb;
    end
    if (s_q.rsp.bvalid && axil_req.bready)
      s_d.rsp.bvalid = 1'b0;

    do_write = s_q.aw_hold && s_q.w_hold && !s_q.rsp.bvalid;
    wsel = esq_decode(s_q.aw_addr);
    widx = s_q.aw_addr[4:2];
    merged = 32'h0;
    if (do_write)
    begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = (wsel == ESQ_SEL_NONE) ? `ESQ_RESP_SLVERR : `ESQ_RESP_OKAY;
      case (wsel)
        ESQ_SEL_CTRL:
        begin
          if (s_q.w_strb[0])
            s_d.ctrl = s_q.w_data[7:0];
        end
        ESQ_SEL_MODE:
        begin
          if (s_q.w_strb[0])
            s_d.mode = s_q.w_data[7:0];
        end
        ESQ_SEL_IRQS:
        begin
          if (s_q.w_strb[0])
            ev_clr = s_q.w_data[`ESQ_NEV-1:0];
        end
        ESQ_SEL_IRQM:
        begin
          mask_we = s_q.w_strb[0];
        end
        ESQ_SEL_RAMP:
        begin
          merged = esq_merge(32'(s_q.ramp[widx]), s_q.w_data, s_q.w_strb);
          s_d.ramp[widx] = merged[`ESQ_TW-1:0];
        end
        ESQ_SEL_DLY:
        begin
          // hazard: a delay shorter than the ramp cuts torque while still moving
          merged = esq_merge(32'(s_q.dly[widx]), s_q.w_data, s_q.w_strb);
          s_d.dly[widx] = merged[`ESQ_TW-1:0];
        end
        default:
        begin
          merged = 32'h0;
        end
      endcase
    end
    s_d.rsp.awready = !s_d.aw_hold;
    s_d.rsp.wready = !s_d.w_hold;

    // read channel: one word answered the cycle after the address is taken
    rsel = esq_decode(axil_req.araddr);
    ridx = axil_req.araddr[4:2];
    if (s_q.rsp.rvalid && axil_req.rready)
      s_d.rsp.rvalid = 1'b0;
    if (axil_req.arvalid && s_q.rsp.arready)
    begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp = `ESQ_RESP_OKAY;
      s_d.rsp.rdata = 32'h0;
      case (rsel)
        ESQ_SEL_CTRL:
          s_d.rsp.rdata = {24'h0, s_q.ctrl};
        ESQ_SEL_STAT:
        begin
          s_d.rsp.rdata[`ESQ_STAT_ACTIVE] = s_q.active;
          s_d.rsp.rdata[`ESQ_STAT_READY] = s_q.ready;
          s_d.rsp.rdata[`ESQ_STAT_POSCTL] = s_q.posctl;
          s_d.rsp.rdata[`ESQ_STAT_ALARM] = s_q.alarm;
          s_d.rsp.rdata[`ESQ_STAT_BRAKING] = |brk_w;
          s_d.rsp.rdata[`ESQ_STAT_DRVOFF] = s_q.all_off;
        end
        ESQ_SEL_MODE:
          s_d.rsp.rdata = {24'h0, s_q.mode};
        ESQ_SEL_ALARM:
          s_d.rsp.rdata = s_q.alarm ? {16'h0, `ESQ_ALARM_NUM} : 32'h0;
        ESQ_SEL_IRQS:
          s_d.rsp.rdata = 32'(irq_stat);
        ESQ_SEL_IRQM:
          s_d.rsp.rdata = 32'(irq_mask);
        ESQ_SEL_RAMP:
          s_d.rsp.rdata = 32'(s_q.ramp[ridx]);
        ESQ_SEL_DLY:
          s_d.rsp.rdata = 32'(s_q.dly[ridx]);
        default:
          s_d.rsp.rresp = `ESQ_RESP_SLVERR;
      endcase
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;

    // stop sequencing; request bits are levels owned by the machine logic
    stop_req = s_q.ctrl[`ESQ_CTRL_STOP];
    ack_req = s_q.ctrl[`ESQ_CTRL_ACK];
    rst_req = s_q.mode[`ESQ_MODE_RESET];
    case (s_q.fsm)
      ESQ_IDLE:
      begin
        // no stop: every other control bit keeps its normal meaning
        if (stop_req)
        begin
          s_d.fsm = ESQ_ACTIVE;
          s_d.active = 1'b1;
          s_d.alarm = 1'b1;
          s_d.ready = 1'b0;
          s_d.prog_hold = 1'b1;
          ev_set[`ESQ_EV_ENTER] = 1'b1;
        end
      end
      ESQ_ACTIVE:
      begin
        // reset without a prior acknowledge is ignored here
        if (ack_req)
          s_d.fsm = ESQ_ACKED;
      end
      ESQ_ACKED:
      begin
        // a still-pressed button keeps the state, even with both bits set
        if (!ack_req)
          s_d.fsm = ESQ_ACTIVE;
        else if (rst_req && !stop_req)
        begin
          s_d.fsm = ESQ_IDLE;
          s_d.active = 1'b0;
          s_d.alarm = 1'b0;
          s_d.ready = 1'b1;
          s_d.posctl = 1'b1;
          s_d.prog_hold = 1'b0;
          s_d.prog_abort = 1'b1;
          s_d.pos_correct = 1'b1;
          ev_set[`ESQ_EV_LEAVE] = 1'b1;
        end
      end
      default:
        s_d.fsm = ESQ_IDLE;
    endcase

    // position control ends once every drive has lost its enable
    s_d.all_off = s_q.active && (den_w == '0);
    if (s_d.all_off && !s_q.all_off)
    begin
      s_d.posctl = 1'b0;
      ev_set[`ESQ_EV_DRVOFF] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // power-on lands in idle with ctrl cleared; a stop needs a fresh write of the request
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready <= 1'b1;
      s_q.rsp.arready <= 1'b1;
      s_q.ramp <= {`ESQ_AXES{RAMP_CYCLES}};
      s_q.dly <= {`ESQ_AXES{DLY_CYCLES}};
      s_q.fsm <= ESQ_IDLE;
      s_q.ready <= 1'b1;
      s_q.posctl <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // axis and status signals leave the block, along with the prog_hold, prog_abort and pos_correct machine outputs
  assign axil_rsp = s_q.rsp;
  assign irq = irq_w;
  assign estop_active = s_q.active;
  assign control_ready = s_q.ready;
  assign pos_ctrl_active = s_q.posctl;
  assign alarm_active = s_q.alarm;
  assign prog_hold = s_q.prog_hold;
  assign prog_abort = s_q.prog_abort;
  assign pos_correct = s_q.pos_correct;
  assign axis_braking = brk_w;
  assign drive_enable = den_w;

endmodule : esq_sequencer

`default_nettype wire

// ### esq_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "esq_consts.svh"

module esq_seq_monitor
  import esq_pkg::*;
#(
  parameter logic [`ESQ_TW-1:0] RAMP_CYCLES = `ESQ_TW'(`ESQ_RAMP_CYC),
  parameter logic [`ESQ_TW-1:0] DLY_CYCLES = `ESQ_TW'(`ESQ_DLY_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire esq_pkg::esq_axil_req_t axil_req,
  input wire esq_pkg::esq_axil_rsp_t axil_rsp,
  input wire logic irq,
  input wire logic estop_active,
  input wire logic control_ready,
  input wire logic pos_ctrl_active,
  input wire logic alarm_active,
  input wire logic prog_hold,
  input wire logic prog_abort,
  input wire logic pos_correct,
  input wire logic [`ESQ_AXES-1:0] axis_braking,
  input wire logic [`ESQ_AXES-1:0] drive_enable
);
  // ----------------------------------------------------------------------
  // cycles spent in the stop state, saturating so a long stop never wraps
  // ----------------------------------------------------------------------
  logic [`ESQ_TW-1:0] cnt_q;
  logic [`ESQ_TW-1:0] cnt_d;

  always_comb
  begin
    cnt_d = !estop_active ? '0 : ((&cnt_q) ? cnt_q : cnt_q + 1'b1);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ready_tracks_a: assert property (control_ready == !estop_active)
    else $error("control ready disagrees with stop state");
  alarm_tracks_a: assert property (alarm_active == estop_active)
    else $error("alarm disagrees with stop state");
  brake_ramp_a: assert property (estop_active |->
    axis_braking == ((cnt_q != 0 && cnt_q <= RAMP_CYCLES) ? 4'hF : 4'h0))
    else $error("braking ramp window wrong");
  drive_delay_a: assert property (estop_active |->
    drive_enable == ((cnt_q <= DLY_CYCLES) ? 4'hF : 4'h0))
    else $error("drive enable dropped at wrong time");
  posctl_drop_a: assert property (estop_active |->
    pos_ctrl_active == (cnt_q <= DLY_CYCLES + 24'h1))
    else $error("position control not following drives off");
  leave_pulse_a: assert property ($fell(estop_active) |->
    (prog_abort && pos_correct) ##1 (drive_enable == 4'hF && !prog_abort))
    else $error("leave effects missing");
  pulse_cause_a: assert property ((prog_abort || pos_correct) |-> $fell(estop_active))
    else $error("abort pulse without leaving stop");
  drive_idle_a: assert property (!estop_active && !$past(estop_active) |->
    drive_enable == 4'hF)
    else $error("drive enable low outside stop");

  enter_c: cover property ($rose(estop_active));
  leave_c: cover property (prog_abort);
  slverr_c: cover property (axil_rsp.bvalid && axil_rsp.bresp == `ESQ_RESP_SLVERR);
endmodule : esq_seq_monitor

bind esq_sequencer esq_seq_monitor #(.RAMP_CYCLES(RAMP_CYCLES), .DLY_CYCLES(DLY_CYCLES)) mon_u (
  .sys_clk, .rst_n, .axil_req, .axil_rsp, .irq, .estop_active, .control_ready,
  .pos_ctrl_active, .alarm_active, .prog_hold, .prog_abort, .pos_correct,
  .axis_braking, .drive_enable
);

`default_nettype wire

// ### esq_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "esq_consts.svh"

// machine logic controller side: it owns the register bus and writes the
// pushbutton copies into the control and mode bytes
module esq_plc_model (
  input wire logic sys_clk,
  input wire esq_pkg::esq_axil_rsp_t axil_rsp,
  output var esq_pkg::esq_axil_req_t axil_req,
  output var logic hung
);
  import esq_pkg::*;

  initial
  begin
    axil_req = '0;
    hung = 1'b0;
  end

  // each access starts one edge late so a release is never overwritten
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n = 0;
    @(posedge sys_clk);
    axil_req.awvalid <= 1'b1;
    axil_req.awaddr <= a;
    axil_req.wvalid <= 1'b1;
    axil_req.wdata <= d;
    axil_req.wstrb <= 4'hF;
    axil_req.bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (axil_rsp.awready) axil_req.awvalid <= 1'b0;
      if (axil_rsp.wready) axil_req.wvalid <= 1'b0;
      n++;
    end while (!axil_rsp.bvalid && n < 60);
    axil_req.bready <= 1'b0;
    resp = axil_rsp.bresp;
    // blocking so the caller sees the flag before it returns
    if (n >= 60) hung = 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n = 0;
    @(posedge sys_clk);
    axil_req.arvalid <= 1'b1;
    axil_req.araddr <= a;
    axil_req.rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (axil_rsp.arready) axil_req.arvalid <= 1'b0;
      n++;
    end while (!axil_rsp.rvalid && n < 60);
    axil_req.rready <= 1'b0;
    d = axil_rsp.rdata;
    resp = axil_rsp.rresp;
    if (n >= 60) hung = 1'b1;
  endtask : rd
endmodule : esq_plc_model

`default_nettype wire

// ### esq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "esq_consts.svh"

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module testbench;
  import esq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  esq_axil_req_t axil_req;
  esq_axil_rsp_t axil_rsp;
  logic irq, estop_active, control_ready, pos_ctrl_active, alarm_active;
  logic prog_hold, prog_abort, pos_correct, hung;
  logic [3:0] axis_braking, drive_enable;
  logic [31:0] rdat;
  logic [1:0] resp;
  int miscompares = 0;
  int checked = 0;
  int aborts = 0;
  int corrects = 0;

  always #20 sys_clk = ~sys_clk;

  // short ramp and a longer off delay keep the run brief
  esq_sequencer #(.RAMP_CYCLES(24'h8), .DLY_CYCLES(24'h10)) dut_u (
    .sys_clk, .rst_n, .axil_req, .axil_rsp, .irq, .estop_active, .control_ready,
    .pos_ctrl_active, .alarm_active, .prog_hold, .prog_abort, .pos_correct,
    .axis_braking, .drive_enable);
  esq_plc_model plc_u (.sys_clk, .axil_rsp, .axil_req, .hung);

  always @(posedge sys_clk)
  begin
    if (prog_abort === 1'b1) aborts++;
    if (pos_correct === 1'b1) corrects++;
  end

  task end_sim;
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    plc_u.wr(a, d, resp);
    if (hung) begin miscompares++; end_sim(); end
    `CHK($sformatf("bresp %h", a), er, resp)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    plc_u.rd(a, rdat, resp);
    if (hung) begin miscompares++; end_sim(); end
    `CHK($sformatf("rdata %h", a), e, rdat)
    `CHK($sformatf("rresp %h", a), er, resp)
  endtask : rd

  task automatic wait_stop(input logic v);
    int n = 0;
    while (estop_active !== v && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 60) begin miscompares++; end_sim(); end
  endtask : wait_stop

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    `CHK("ready", 1'b1, control_ready)
    rd(`ESQ_OFF_STAT, 32'h18, `ESQ_RESP_OKAY);
    rd(8'h18, 32'h0, `ESQ_RESP_SLVERR);
    wr(8'h18, 32'h1, `ESQ_RESP_SLVERR);
    wr(`ESQ_OFF_IRQ_MASK, 32'h7, `ESQ_RESP_OKAY);
    rd(`ESQ_OFF_IRQ_MASK, 32'h7, `ESQ_RESP_OKAY);
    rd(8'h20, 32'h8, `ESQ_RESP_OKAY);
    rd(8'h4C, 32'h10, `ESQ_RESP_OKAY);
    wr(8'h2C, 32'h8, `ESQ_RESP_OKAY);
    rd(8'h2C, 32'h8, `ESQ_RESP_OKAY);
    rd(8'h30, 32'h0, `ESQ_RESP_SLVERR);
    wr(`ESQ_OFF_CTRL, 32'h2, `ESQ_RESP_OKAY);
    wait_stop(1'b1);
    `CHK("alarm", 1'b1, alarm_active)
    `CHK("hold", 1'b1, prog_hold)
    rd(`ESQ_OFF_ALARM, 32'h0BB8, `ESQ_RESP_OKAY);
    rd(`ESQ_OFF_STAT, 32'h72, `ESQ_RESP_OKAY);
    `CHK("braking", 4'hF, axis_braking)
    repeat (30) @(posedge sys_clk);
    `CHK("drive", 4'h0, drive_enable)
    `CHK("braking", 4'h0, axis_braking)
    rd(`ESQ_OFF_STAT, 32'hA2, `ESQ_RESP_OKAY);
    rd(`ESQ_OFF_IRQ_STAT, 32'h5, `ESQ_RESP_OKAY);
    `CHK("irq", 1'b1, irq)
    wr(`ESQ_OFF_IRQ_STAT, 32'h7, `ESQ_RESP_OKAY);
    rd(`ESQ_OFF_IRQ_STAT, 32'h0, `ESQ_RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    // button released, then reset alone: the stop state must hold
    wr(`ESQ_OFF_CTRL, 32'h0, `ESQ_RESP_OKAY);
    wr(`ESQ_OFF_MODE, 32'h80, `ESQ_RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    `CHK("active", 1'b1, estop_active)
    wr(`ESQ_OFF_MODE, 32'h0, `ESQ_RESP_OKAY);
    wr(`ESQ_OFF_CTRL, 32'h4, `ESQ_RESP_OKAY);
    wr(`ESQ_OFF_MODE, 32'h80, `ESQ_RESP_OKAY);
    wait_stop(1'b0);
    `CHK("ready", 1'b1, control_ready)
    `CHK("posctl", 1'b1, pos_ctrl_active)
    `CHK("alarm", 1'b0, alarm_active)
    `CHK("hold", 1'b0, prog_hold)
    wr(`ESQ_OFF_CTRL, 32'h0, `ESQ_RESP_OKAY);
    wr(`ESQ_OFF_MODE, 32'h0, `ESQ_RESP_OKAY);
    `CHK("aborts", 1, aborts)
    `CHK("corrects", 1, corrects)
    `CHK("drive", 4'hF, drive_enable)
    rd(`ESQ_OFF_IRQ_STAT, 32'h2, `ESQ_RESP_OKAY);
    rd(`ESQ_OFF_ALARM, 32'h0, `ESQ_RESP_OKAY);
    // masked entry must keep the interrupt line quiet
    wr(`ESQ_OFF_IRQ_STAT, 32'h7, `ESQ_RESP_OKAY);
    wr(`ESQ_OFF_IRQ_MASK, 32'h0, `ESQ_RESP_OKAY);
    wr(`ESQ_OFF_CTRL, 32'h2, `ESQ_RESP_OKAY);
    wait_stop(1'b1);
    repeat (2) @(posedge sys_clk);
    `CHK("irq", 1'b0, irq)
    // acknowledge and reset while the button is still pressed: state holds
    wr(`ESQ_OFF_CTRL, 32'h6, `ESQ_RESP_OKAY);
    wr(`ESQ_OFF_MODE, 32'h80, `ESQ_RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    `CHK("active", 1'b1, estop_active)
    // power-on in mid stop
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    `CHK("active", 1'b0, estop_active)
    rd(`ESQ_OFF_CTRL, 32'h0, `ESQ_RESP_OKAY);
    wr(`ESQ_OFF_CTRL, 32'h2, `ESQ_RESP_OKAY);
    wait_stop(1'b1);
    end_sim();
  end
endmodule : testbench

`default_nettype wire
